// File: verilog/tat_consts.svh
// Offsets, field positions, reset values and timing for the thermal alarm.
// Included by the design; definitions only.
`ifndef TAT_CONSTS_SVH
`define TAT_CONSTS_SVH
// Register indices; byte address is four times the index
`define TAT_IDX_TEMP      3'h0
`define TAT_IDX_CFG       3'h1
`define TAT_IDX_HYS       3'h2
`define TAT_IDX_OVL       3'h3
`define TAT_IDX_STAT      3'h4
// Configuration field positions
`define TAT_CFG_SHUTDOWN  0
`define TAT_CFG_INTMODE   1
`define TAT_CFG_POLARITY  2
`define TAT_CFG_FAULT_LO  3
`define TAT_CFG_FAULT_HI  4
`define TAT_CFG_RES_LO    5
`define TAT_CFG_RES_HI    6
`define TAT_CFG_SINGLE    7
// Status field positions
`define TAT_STAT_ALARM    0
`define TAT_STAT_STANDBY  1
`define TAT_STAT_ARMHYS   2
`define TAT_STAT_TIMEOUT  3
// Reset values
`define TAT_RST_CFG       8'h00
`define TAT_RST_HYS       16'h4800
`define TAT_RST_OVL       16'h5000
`define TAT_RST_TEMP      16'h0000
// Timing
`define TAT_CLK_MHZ       125
`define TAT_TIMEOUT_US    25000
`endif

// File: verilog/tat_pkg.sv
// Types shared by the thermal alarm design.
// Needs nothing from tat_consts.svh; the design includes that file itself.
package tat_pkg;
   // Conversion sequencer states
   typedef enum logic [0:0] {
      TAT_CV_IDLE = 1'b0,
      TAT_CV_BUSY = 1'b1
   } tat_cv_e;
   // Synchronised two-wire pin samples
   typedef struct packed {
      logic s1;
      logic s2;
      logic d;
   } tat_pin_s;
   // Complete state of the block
   typedef struct packed {
      logic [7:0]  cfg;
      logic [15:0] ovl;
      logic [15:0] hys;
      logic [15:0] temp;
      logic [2:0]  cnt;
      logic        pend;
      logic        alarm;
      logic        arm_hys;
      tat_cv_e     cv;
      logic        single_pend;
      logic        wait_n;
      logic [31:0] rdata;
      logic        conv_start;
      logic        oe;
      tat_pin_s    scl;
      tat_pin_s    sda;
      logic        in_frame;
      logic [23:0] to_cnt;
      logic        to_flag;
      logic        ser_rst;
   } tat_state_s;
endpackage

// File: verilog/tat_thermal_alarm.sv
// Thermal alarm and conversion control of a digital temperature sensor.
// Assumes a converter on clk_in answering each start with one done pulse,
// an Avalon-MM master, and raw two-wire pins from outside this clock.
//
// Added by the designer: the address map and register access over Avalon-MM.
`timescale 1ns/1ns
`include "tat_consts.svh"
module tat_thermal_alarm #(
   parameter int TIMEOUT_CYCLES = `TAT_TIMEOUT_US * `TAT_CLK_MHZ
) (
   input  wire logic        clk_in,
   input  wire logic        srst_in,
   input  wire logic [4:0]  avm_address_in,
   input  wire logic        avm_read_in,
   input  wire logic        avm_write_in,
   input  wire logic [31:0] avm_writedata_in,
   input  wire logic [3:0]  avm_byteenable_in,
   output logic      [31:0] avm_readdata_out,
   output logic             avm_waitrequest_out,
   input  wire logic        conv_done_in,
   input  wire logic [15:0] conv_data_in,
   output logic             conv_start_out,
   input  wire logic        scl_in,
   input  wire logic        sda_in,
   output logic             serial_reset_out,
   output logic             alarm_output_out,
   output logic             alarm_output_oe_out
);
   // Fault count decode: 00->1, 01->2, 10->4, 11->6
   function automatic logic [2:0] fault_need(input logic [1:0] sel);
      case (sel)
         2'h0:    fault_need = 3'h1;
         2'h1:    fault_need = 3'h2;
         2'h2:    fault_need = 3'h4;
         default: fault_need = 3'h6;
      endcase
   endfunction

   // Resolution mask: 00->9, 01->10, 10->11, 11->12 data bits
   function automatic logic [15:0] res_mask(input logic [1:0] sel);
      case (sel)
         2'h0:    res_mask = 16'hFF80;
         2'h1:    res_mask = 16'hFFC0;
         2'h2:    res_mask = 16'hFFE0;
         default: res_mask = 16'hFFF0;
      endcase
   endfunction

   tat_pkg::tat_state_s st_q;
   tat_pkg::tat_state_s st_d;

   logic [2:0]  idx;
   logic        acc;
   logic        rd_ack;
   logic        wr_ack;
   logic [15:0] mask;
   logic [15:0] sample;
   logic        done_evt;
   logic        watch_hys;
   logic        cond;
   logic        fire;
   logic        int_mode;
   logic        sd_rise;
   logic        start_seen;
   logic        stop_seen;
   logic [7:0]  wcfg;
   logic [31:0] rd_mux;

   // Bus decode; an access is taken on the edge where waitrequest is low
   always_comb begin
      idx      = avm_address_in[4:2];
      acc      = (avm_read_in || avm_write_in) && !st_q.wait_n;
      rd_ack   = acc && avm_read_in;
      wr_ack   = acc && avm_write_in;
      mask     = res_mask({st_q.cfg[`TAT_CFG_RES_HI],
                           st_q.cfg[`TAT_CFG_RES_LO]});
      sample   = conv_data_in & mask;
      done_evt = conv_done_in && (st_q.cv == tat_pkg::TAT_CV_BUSY);
      int_mode = st_q.cfg[`TAT_CFG_INTMODE];
      // Comparator watches for release while active; interrupt alternates
      watch_hys = int_mode ? st_q.arm_hys : st_q.alarm;
      // Only resolution-wide threshold bits take part
      cond = watch_hys
           ? ($signed(sample) < $signed(st_q.hys & mask))
           : ($signed(sample) > $signed(st_q.ovl & mask));
      fire = done_evt && cond && st_q.pend;
      wcfg = avm_writedata_in[7:0];
      sd_rise = wr_ack && (idx == `TAT_IDX_CFG) && avm_byteenable_in[0]
              && wcfg[`TAT_CFG_SHUTDOWN]
              && !st_q.cfg[`TAT_CFG_SHUTDOWN];
      // Start and stop seen on synchronised, delayed copies
      start_seen = st_q.scl.s2 && st_q.scl.d && st_q.sda.d && !st_q.sda.s2;
      stop_seen  = st_q.scl.s2 && st_q.scl.d && !st_q.sda.d && st_q.sda.s2;
   end

   // Read mux; single-conversion bit is never stored so reads zero
   always_comb begin
      rd_mux = 32'h0000_0000;
      case (idx)
         `TAT_IDX_TEMP: rd_mux[15:0] = st_q.temp;
         `TAT_IDX_CFG:  rd_mux[7:0]  = st_q.cfg;
         `TAT_IDX_HYS:  rd_mux[15:0] = st_q.hys;
         `TAT_IDX_OVL:  rd_mux[15:0] = st_q.ovl;
         `TAT_IDX_STAT: begin
            rd_mux[`TAT_STAT_ALARM]   = st_q.alarm;
            rd_mux[`TAT_STAT_STANDBY] = (st_q.cv == tat_pkg::TAT_CV_IDLE)
                                        && st_q.cfg[`TAT_CFG_SHUTDOWN];
            rd_mux[`TAT_STAT_ARMHYS]  = st_q.arm_hys;
            rd_mux[`TAT_STAT_TIMEOUT] = st_q.to_flag;
         end
         default:       rd_mux = 32'h0000_0000;
      endcase
   end

   // Next-state logic for the whole block
   always_comb begin
      st_d = st_q;
      st_d.conv_start = 1'b0;
      st_d.ser_rst    = 1'b0;

      // Avalon slave: one wait cycle, then answer for exactly one edge
      if (acc) begin
         st_d.wait_n = 1'b1;
      end else if (avm_read_in || avm_write_in) begin
         st_d.wait_n = 1'b0;
         st_d.rdata  = rd_mux;
      end

      // Register writes; bus stays live in shutdown
      if (wr_ack) begin
         case (idx)
            `TAT_IDX_CFG: begin
               if (avm_byteenable_in[0]) begin
                  st_d.cfg = {1'b0, wcfg[6:0]};
                  // Single request only counts once already shut down
                  if (wcfg[`TAT_CFG_SINGLE] && wcfg[`TAT_CFG_SHUTDOWN]
                      && st_q.cfg[`TAT_CFG_SHUTDOWN]) begin
                     st_d.single_pend = 1'b1;
                  end
                  if (!wcfg[`TAT_CFG_SHUTDOWN]) begin
                     st_d.single_pend = 1'b0;
                  end
               end
            end
            `TAT_IDX_HYS: begin
               if (avm_byteenable_in[0]) st_d.hys[7:0]  = avm_writedata_in[7:0];
               if (avm_byteenable_in[1]) st_d.hys[15:8] = avm_writedata_in[15:8];
            end
            `TAT_IDX_OVL: begin
               if (avm_byteenable_in[0]) st_d.ovl[7:0]  = avm_writedata_in[7:0];
               if (avm_byteenable_in[1]) st_d.ovl[15:8] = avm_writedata_in[15:8];
            end
            default: begin
            end
         endcase
      end

      // Conversion sequencer; free-running from reset needs no host
      case (st_q.cv)
         tat_pkg::TAT_CV_IDLE: begin
            if (!st_q.cfg[`TAT_CFG_SHUTDOWN] || st_q.single_pend) begin
               st_d.cv          = tat_pkg::TAT_CV_BUSY;
               st_d.conv_start  = 1'b1;
               st_d.single_pend = 1'b0;
            end
         end
         tat_pkg::TAT_CV_BUSY: begin
            // A shutdown request lets the running conversion finish
            if (conv_done_in) begin
               st_d.cv = tat_pkg::TAT_CV_IDLE;
            end
         end
         default: st_d.cv = tat_pkg::TAT_CV_IDLE;
      endcase

      // Store result unless a host read is under way; old value then stands
      if (done_evt && !avm_read_in && !st_q.in_frame) begin
         st_d.temp = sample;
      end

      // Fault queue: uninterrupted qualifying runs only
      if (done_evt) begin
         if (!cond) begin
            st_d.cnt  = 3'h0;
            st_d.pend = 1'b0;
         end else if (st_q.pend) begin
            st_d.cnt  = 3'h0;
            st_d.pend = 1'b0;
         end else if (st_q.cnt + 3'h1 >= fault_need(
                         {st_q.cfg[`TAT_CFG_FAULT_HI],
                          st_q.cfg[`TAT_CFG_FAULT_LO]})) begin
            st_d.pend = 1'b1;
         end else begin
            st_d.cnt  = st_q.cnt + 3'h1;
         end
      end

      // Interrupt clear by any data read or by entering shutdown
      if (int_mode && ((rd_ack && idx <= `TAT_IDX_OVL) || sd_rise)) begin
         st_d.alarm = 1'b0;
      end
      // Comparator keeps its level through shutdown; a fire wins a clear
      if (fire) begin
         if (int_mode) begin
            st_d.alarm   = 1'b1;
            st_d.arm_hys = !st_q.arm_hys;
         end else begin
            st_d.alarm   = !st_q.alarm;
         end
      end

      // Open drain: pull low when pin level must be low
      st_d.oe = st_d.alarm ^ st_d.cfg[`TAT_CFG_POLARITY];

      // Pin synchronisers; the second stage and its delayed copy feed logic
      st_d.scl.s1 = scl_in;
      st_d.scl.s2 = st_q.scl.s1;
      st_d.scl.d  = st_q.scl.s2;
      st_d.sda.s1 = sda_in;
      st_d.sda.s2 = st_q.sda.s1;
      st_d.sda.d  = st_q.sda.s2;

      // Frame tracking and stuck-low data timeout
      if (start_seen) begin
         st_d.in_frame = 1'b1;
         st_d.to_cnt   = 24'h00_0000;
      end else if (stop_seen) begin
         st_d.in_frame = 1'b0;
      end else if (st_q.in_frame) begin
         if (st_q.sda.s2) begin
            st_d.to_cnt = 24'h00_0000;
         end else if (st_q.to_cnt >= 24'(TIMEOUT_CYCLES)) begin
            // Drop the frame and wait for a new start
            st_d.in_frame = 1'b0;
            st_d.ser_rst  = 1'b1;
            st_d.to_flag  = 1'b1;
            st_d.to_cnt   = 24'h00_0000;
         end else begin
            st_d.to_cnt = st_q.to_cnt + 24'h00_0001;
         end
      end
      if (rd_ack && idx == `TAT_IDX_STAT) begin
         st_d.to_flag = st_d.ser_rst;  // Read clears; a new timeout wins
      end
   end

   // State register
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         st_q             <= '0;
         st_q.cfg         <= `TAT_RST_CFG;
         st_q.hys         <= `TAT_RST_HYS;
         st_q.ovl         <= `TAT_RST_OVL;
         st_q.temp        <= `TAT_RST_TEMP;
         st_q.cv          <= tat_pkg::TAT_CV_IDLE;
         st_q.wait_n      <= 1'b1;
         st_q.scl         <= 3'h7;
         st_q.sda         <= 3'h7;
      end else begin
         st_q <= st_d;
      end
   end

   // Outputs straight from the state register; alarm pin data is tied low
   always_comb begin
      avm_readdata_out    = st_q.rdata;
      avm_waitrequest_out = st_q.wait_n;
      conv_start_out      = st_q.conv_start;
      serial_reset_out    = st_q.ser_rst;
      alarm_output_out    = 1'b0;
      alarm_output_oe_out = st_q.oe;
   end

   // Checks
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (srst_in);

   single_reads_zero_a: assert property (
      rd_ack && idx == `TAT_IDX_CFG |-> !avm_readdata_out[7])
      else $error("single-conversion bit read back as one");
   // Checked at store time; a later resolution change keeps the old value
   temp_format_a: assert property (
      done_evt && !avm_read_in && !st_q.in_frame
      |=> (st_q.temp & ~$past(mask)) == 16'h0000)
      else $error("temperature has bits below resolution");
   fault_clear_a: assert property (
      done_evt && !cond |=> st_q.cnt == 3'h0 && !st_q.pend)
      else $error("fault counter kept count after a pass");
   int_read_clear_a: assert property (
      int_mode && rd_ack && idx <= `TAT_IDX_OVL && !fire |=> !st_q.alarm)
      else $error("interrupt alarm survived a register read");
   cmp_alarm_hold_a: assert property (
      !int_mode && !fire && !$past(int_mode) |=> $stable(st_q.alarm))
      else $error("comparator alarm changed without a fire");
   pin_level_a: assert property (
      ##1 alarm_output_oe_out ==
          (st_q.alarm ^ st_q.cfg[`TAT_CFG_POLARITY]))
      else $error("alarm pin enable disagrees with polarity");
   fire_pending_a: assert property (
      $changed(st_q.alarm) && !$past(rd_ack) && !$past(sd_rise)
      |-> $past(st_q.pend) && $past(done_evt))
      else $error("alarm moved without a confirmed fault");
   standby_entry_a: assert property (
      done_evt && st_q.cfg[`TAT_CFG_SHUTDOWN] && !st_q.single_pend
      |=> st_q.cv == tat_pkg::TAT_CV_IDLE
      ##1 (!conv_start_out || $past(st_q.single_pend)
           || !$past(st_q.cfg[`TAT_CFG_SHUTDOWN])))
      else $error("conversion restarted in shutdown");
   single_start_a: assert property (
      st_q.cv == tat_pkg::TAT_CV_IDLE && st_q.single_pend
      |=> conv_start_out ##1 !st_q.single_pend)
      else $error("single request did not start one conversion");
   bus_timeout_a: assert property (
      st_q.in_frame && !start_seen && !stop_seen && !st_q.sda.s2
      && st_q.to_cnt >= 24'(TIMEOUT_CYCLES)
      |=> serial_reset_out && !st_q.in_frame)
      else $error("stuck data line did not reset serial side");

   int_fire_c:     cover property (int_mode && fire);
   cmp_release_c:  cover property (!int_mode && fire && st_q.alarm);
   single_conv_c:  cover property (st_q.single_pend ##1 conv_start_out);
   timeout_c:      cover property (serial_reset_out);
endmodule

// File: testbench/tat_far_model.sv
// Far-side model: converter answering each start, and a two-wire host.
// Assumes the bench sets latency, result and frame length.
`timescale 1ns/1ns
module tat_far_model (
   input  wire logic        clk_in,
   input  wire logic        conv_start_in,
   input  wire logic [15:0] temp_in,
   input  wire logic [7:0]  lat_in,
   input  wire logic        frame_go_in,
   input  wire logic [7:0]  hold_in,
   output logic             conv_done_out = 1'b0,
   output logic [15:0]      conv_data_out = 16'h0000,
   output logic             scl_out = 1'b1,
   output logic             sda_out = 1'b1
);
   logic       busy_q = 1'b0;
   logic [7:0] wait_q = 8'h00;
   // One done per start; data toggles outside done so stale values show
   always_ff @(posedge clk_in) begin
      conv_done_out <= 1'b0;
      conv_data_out <= ~conv_data_out;
      if (conv_start_in) begin
         busy_q <= 1'b1;
         wait_q <= lat_in;
      end else if (busy_q && wait_q == 8'h00) begin
         busy_q        <= 1'b0;
         conv_done_out <= 1'b1;
         conv_data_out <= temp_in;
      end else if (busy_q) begin
         wait_q <= wait_q - 8'h01;
      end
   end
   // Frame: START, clock runs only inside frame, data held low, STOP
   always begin
      @(posedge frame_go_in);
      #13 sda_out = 1'b0;
      repeat (hold_in) #40 scl_out = ~scl_out;
      scl_out = 1'b1;
      #40 sda_out = 1'b1;
   end
endmodule

// File: testbench/tb.sv
// Self-checking bench for the thermal alarm block.
// Assumes the far-side model and the design sources are compiled first.
`timescale 1ns/1ns
module tb;
   logic        clk_in, srst_in, avm_read_in, avm_write_in;
   logic [4:0]  avm_address_in;
   logic [31:0] avm_writedata_in, avm_readdata_out;
   logic        avm_waitrequest_out, conv_done_in, conv_start_out;
   logic [15:0] conv_data_in, temp_val, v;
   logic        scl_in, sda_in, serial_reset_out, frame_go;
   logic        alarm_output_out, alarm_output_oe_out;
   logic [7:0]  hold, lat;
   integer      seed = 66994;
   int          failures = 0, checks = 0, starts = 0, sresets = 0, s0;
   int          nf[4] = '{1, 2, 4, 6};
   logic [31:0] exp_q[$], msk_q[$];

   tat_thermal_alarm #(.TIMEOUT_CYCLES(200)) i_tat_thermal_alarm (
      .clk_in(clk_in), .srst_in(srst_in),
      .avm_address_in(avm_address_in), .avm_read_in(avm_read_in),
      .avm_write_in(avm_write_in), .avm_writedata_in(avm_writedata_in),
      .avm_byteenable_in(4'hF), .avm_readdata_out(avm_readdata_out),
      .avm_waitrequest_out(avm_waitrequest_out),
      .conv_done_in(conv_done_in), .conv_data_in(conv_data_in),
      .conv_start_out(conv_start_out), .scl_in(scl_in), .sda_in(sda_in),
      .serial_reset_out(serial_reset_out),
      .alarm_output_out(alarm_output_out),
      .alarm_output_oe_out(alarm_output_oe_out));
   tat_far_model i_tat_far_model (
      .clk_in(clk_in), .conv_start_in(conv_start_out), .temp_in(temp_val),
      .lat_in(lat), .frame_go_in(frame_go), .hold_in(hold),
      .conv_done_out(conv_done_in), .conv_data_out(conv_data_in),
      .scl_out(scl_in), .sda_out(sda_in));

   // Clock, 8 ns period
   initial begin
      clk_in = 1'b0;
      forever #4 clk_in = ~clk_in;
   end
   task automatic check(input string nm, input logic [31:0] seen, exp);
      checks++;
      if (seen !== exp) begin
         failures++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic test_done();
      if (failures == 0 && checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // Pulse counters; also a fresh converter latency each start
   always @(posedge clk_in) begin
      if (conv_start_out === 1'b1) begin
         starts++;
         lat <= 8'd4 + 8'($unsigned($random(seed)) % 30);
      end
      if (serial_reset_out === 1'b1) sresets++;
   end
   // Read data stand at the edge where waitrequest is low
   always @(posedge clk_in) begin
      if (avm_read_in === 1'b1 && avm_waitrequest_out === 1'b0 &&
          exp_q.size() > 0) begin
         check("readdata", avm_readdata_out & msk_q[0], exp_q[0]);
         void'(exp_q.pop_front());
         void'(msk_q.pop_front());
      end
   end
   // Hold request until waitrequest is seen low, then release
   task automatic bus(input logic wr, input logic [4:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      avm_read_in      <= ~wr;
      avm_write_in     <= wr;
      avm_address_in   <= a;
      avm_writedata_in <= d;
      do begin
         @(posedge clk_in);
         n++;
      end while (avm_waitrequest_out !== 1'b0 && n < 100);
      if (n >= 100) failures++;
      avm_read_in  <= 1'b0;
      avm_write_in <= 1'b0;
      @(posedge clk_in);
   endtask
   task automatic rd(input logic [4:0] a, input logic [31:0] e, m);
      exp_q.push_back(e & m);
      msk_q.push_back(m);
      bus(1'b0, a, 32'h0000_0000);
   endtask
   // Next finished conversion carries t; alarm lands one cycle later
   task automatic conv(input logic [15:0] t);
      int n;
      n = 0;
      temp_val <= t;
      do begin
         @(posedge clk_in);
         n++;
      end while (conv_done_in !== 1'b1 && n < 200);
      if (n >= 200) failures++;
      repeat (2) @(posedge clk_in);
   endtask
   task automatic pin(input logic e);
      check("alarm_oe", {31'h0, alarm_output_oe_out}, {31'h0, e});
   endtask
   task automatic cnt(input string nm, input int seen, exp);
      @(negedge clk_in);
      check(nm, seen, exp);
      @(posedge clk_in);
   endtask
   task automatic run(input int n, input logic [15:0] t);
      repeat (n) conv(t);
   endtask
   // Hang guard
   initial begin
      repeat (60000) @(posedge clk_in);
      failures++;
      test_done();
   end
   // Main sequence
   initial begin
      srst_in = 1'b1;
      avm_read_in = 1'b0;
      avm_write_in = 1'b0;
      avm_address_in = 5'h00;
      avm_writedata_in = 32'h0;
      temp_val = 16'h0000;
      lat = 8'd10;
      hold = 8'd0;
      frame_go = 1'b0;
      repeat (8) @(posedge clk_in);
      srst_in <= 1'b0;
      repeat (100) @(posedge clk_in);
      cnt("started", int'(starts > 2), 1);
      pin(1'b0);
      check("alarm_data", {31'h0, alarm_output_out}, 32'h0);
      rd(5'h04, 32'h00, 32'hFFFF_FFFF);
      rd(5'h08, 32'h4800, 32'hFFFF_FFFF);
      rd(5'h0C, 32'h5000, 32'hFFFF_FFFF);
      rd(5'h14, 32'h0, 32'hFFFF_FFFF);
      rd(5'h1C, 32'h0, 32'hFFFF_FFFF);
      // Every fault count, with a broken run first
      for (int f = 0; f < 4; f++) begin
         bus(1'b1, 5'h04, 32'(f << 3));
         run(nf[f] - 1, 16'h5100);
         conv(16'h4000);
         run(nf[f], 16'h5100);
         pin(1'b0);
         conv(16'h5100);
         pin(1'b1);
         run(nf[f], 16'h4000);
         pin(1'b1);
         conv(16'h4000);
         pin(1'b0);
      end
      // Comparator alarm survives shutdown; single conversion
      bus(1'b1, 5'h04, 32'h00);
      run(2, 16'h5180);
      pin(1'b1);
      bus(1'b1, 5'h04, 32'h01);
      repeat (60) @(posedge clk_in);
      pin(1'b1);
      rd(5'h00, 32'h5180, 32'hFFFF_FFFF);
      s0 = starts;
      temp_val <= 16'h5200;
      repeat (100) @(posedge clk_in);
      cnt("standby", starts, s0);
      bus(1'b1, 5'h04, 32'h81);
      repeat (100) @(posedge clk_in);
      cnt("single", starts, s0 + 1);
      rd(5'h04, 32'h01, 32'hFFFF_FFFF);
      rd(5'h00, 32'h5200, 32'hFFFF_FFFF);
      bus(1'b1, 5'h04, 32'h00);
      run(2, 16'h4000);
      pin(1'b0);
      // Interrupt behaviour: read clears, arming alternates
      bus(1'b1, 5'h04, 32'h02);
      run(2, 16'h5100);
      pin(1'b1);
      rd(5'h04, 32'h02, 32'hFFFF_FFFF);
      pin(1'b0);
      run(2, 16'h5100);
      pin(1'b0);
      run(2, 16'h4000);
      pin(1'b1);
      bus(1'b1, 5'h04, 32'h03);
      pin(1'b0);
      bus(1'b1, 5'h04, 32'h07);
      pin(1'b1);
      bus(1'b1, 5'h04, 32'h03);
      pin(1'b0);
      // Every resolution masks the stored result
      for (int r = 0; r < 4; r++) begin
         bus(1'b1, 5'h04, 32'(r << 5));
         v = 16'($random(seed));
         conv(v);
         rd(5'h00, {16'h0, v & ~(16'h007F >> r)}, 32'hFFFF_FFFF);
      end
      // Short frame passes; long low data resets the serial side
      s0 = sresets;
      hold <= 8'd20;
      frame_go <= 1'b1;
      @(posedge clk_in);
      frame_go <= 1'b0;
      repeat (150) @(posedge clk_in);
      cnt("short_frame", sresets, s0);
      hold <= 8'd60;
      frame_go <= 1'b1;
      @(posedge clk_in);
      frame_go <= 1'b0;
      repeat (350) @(posedge clk_in);
      cnt("timeout", sresets, s0 + 1);
      rd(5'h10, 32'h8, 32'h8);
      rd(5'h10, 32'h0, 32'h8);
      repeat (10) @(posedge clk_in);
      test_done();
   end
endmodule
